// [common/lspc_params.svh]
// Operation
// - clearing enable turns sink off, clears inclusion
// - ramp bit set: step current 1 ms per code
// - ramp bit clear: current code applies at once
// - sink3 mode zero: PWM only, sink3 enable forced zero
// - sink3 mode one (reset): current controlled
// - shared idle code sets current during idle
// - each sink owns an 8-bit current code
// - duty counts 2 MHz cycles, 95 per period
// - duty zero off, 95 or more always on
// - active part own code, idle part shared code
// - dim bit set: duty steps 40 ms each
// - dim bit clear: duty applies immediately
// - duty zero applies immediately even when dimming
// - sinks two and three match sink one, apart from sink3 mode gating
`ifndef LSPC_PARAMS_SVH
`define LSPC_PARAMS_SVH

`define LSPC_IDX_BOOST_INCL 8'h46
`define LSPC_IDX_CTRL 8'h47
`define LSPC_IDX_IDLE 8'h48
`define LSPC_IDX_CUR1 8'h49
`define LSPC_IDX_CUR2 8'h4a
`define LSPC_IDX_CUR3 8'h4b
`define LSPC_IDX_DUTY1 8'h4c
`define LSPC_IDX_DUTY2 8'h4d
`define LSPC_IDX_DUTY3 8'h4e
`define LSPC_IDX_STATUS 8'h4f
`define LSPC_IDX_APP_DUTY1 8'h50
`define LSPC_IDX_APP_DUTY2 8'h51
`define LSPC_IDX_APP_DUTY3 8'h52
`define LSPC_IDX_APP_CUR1 8'h53
`define LSPC_IDX_APP_CUR2 8'h54
`define LSPC_IDX_APP_CUR3 8'h55

`define LSPC_CTRL_EN1 0
`define LSPC_CTRL_RAMP1 1
`define LSPC_CTRL_EN2 2
`define LSPC_CTRL_RAMP2 3
`define LSPC_CTRL_EN3 4
`define LSPC_CTRL_RAMP3 5
`define LSPC_CTRL_MODE3 6
`define LSPC_DUTY_DIM 7
`define LSPC_INCL_LSB 1

`define LSPC_CTRL_RESET 8'h40
`define LSPC_CODE_RESET 8'h00
`define LSPC_DUTY_RESET 8'h00
`define LSPC_INCL_RESET 3'h0

`define LSPC_CLK_PERIOD_NS 10
`define LSPC_PWM_TICK_NS 500
`define LSPC_PWM_TICK_CYCLES (`LSPC_PWM_TICK_NS / `LSPC_CLK_PERIOD_NS)
`define LSPC_PWM_PERIOD 95
`define LSPC_RAMP_STEP_NS 1000000
`define LSPC_RAMP_STEP_CYCLES (`LSPC_RAMP_STEP_NS / `LSPC_CLK_PERIOD_NS)
`define LSPC_DIM_STEP_NS 40000000
`define LSPC_DIM_STEP_CYCLES (`LSPC_DIM_STEP_NS / `LSPC_CLK_PERIOD_NS)

`endif

// [common/lspc_pkg.sv]
package lspc_pkg;
    typedef logic [7:0] lspc_code_t;
    typedef logic [6:0] lspc_duty_t;
    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } lspc_bus_t;
endpackage

// [rtl/lspc_pwm.sv]
`timescale 1ns/1ns
// 2 MHz tick and wrapping pwm phase
module lspc_pwm #(
    parameter int TICK_CYCLES = 50,
    parameter int PERIOD = 95
) (
    input wire logic clock,
    input wire logic rst,
    output logic [6:0] phase
);
    logic [15:0] pre;
    logic [15:0] next_pre;
    logic [6:0] next_phase;

    always_comb begin
        next_pre = pre + 16'd1;
        next_phase = phase;
        if (pre >= 16'(TICK_CYCLES - 1)) begin
            next_pre = 16'd0;
            if (phase >= 7'(PERIOD - 1)) begin
                next_phase = 7'd0;
            end else begin
                next_phase = phase + 7'd1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pre <= 16'd0;
            phase <= 7'd0;
        end else begin
            pre <= next_pre;
            phase <= next_phase;
        end
    end
endmodule // lspc_pwm

// [rtl/lspc_step.sv]
`timescale 1ns/1ns
// moves value toward target one code per step period
module lspc_step #(
    parameter int W = 8,
    parameter int STEP_CYCLES = 100000
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [W-1:0] target,
    input wire logic rampOn,
    input wire logic forceLoad,
    output logic [W-1:0] value,
    output logic busy
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [W-1:0] next_value;

    always_comb begin
        next_value = value;
        next_cnt = cnt;
        if (!rampOn || forceLoad) begin
            next_value = target;
            next_cnt = 32'd0;
        end else if (value == target) begin
            next_cnt = 32'd0;
        end else if (cnt >= 32'(STEP_CYCLES - 1)) begin
            next_cnt = 32'd0;
            if (value < target) begin
                next_value = W'(value + 1'b1);
            end else begin
                next_value = W'(value - 1'b1);
            end
        end else begin
            next_cnt = cnt + 32'd1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            value <= '0;
            cnt <= 32'd0;
        end else begin
            value <= next_value;
            cnt <= next_cnt;
        end
    end

    assign busy = (value != target);
endmodule // lspc_step

// [rtl/lspc_top.sv]
`timescale 1ns/1ns
`include "lspc_params.svh"
// three led sinks: current codes, ramping, pwm, dimming
module lspc_top #(
    parameter int RAMP_STEP_CYCLES = `LSPC_RAMP_STEP_CYCLES,
    parameter int DIM_STEP_CYCLES = `LSPC_DIM_STEP_CYCLES,
    parameter int PWM_TICK_CYCLES = `LSPC_PWM_TICK_CYCLES,
    parameter int PWM_PERIOD = `LSPC_PWM_PERIOD
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [2:0] sinkOn,
    output logic [2:0] pwmActive,
    output logic [2:0] boostInclusion,
    output lspc_pkg::lspc_code_t sink1Code,
    output lspc_pkg::lspc_code_t sink2Code,
    output lspc_pkg::lspc_code_t sink3Code
);
    import lspc_pkg::*;

    // bus slave state
    lspc_bus_t busState;
    lspc_bus_t next_busState;
    logic next_waitrequest;
    logic [31:0] next_readdata;

    // software registers
    lspc_code_t ctrl;
    lspc_code_t next_ctrl;
    lspc_code_t idleCode;
    lspc_code_t next_idleCode;
    lspc_code_t curCode [3];
    lspc_code_t next_curCode [3];
    lspc_code_t dutyReg [3];
    lspc_code_t next_dutyReg [3];
    logic [2:0] incl;
    logic [2:0] next_incl;

    // applied values
    lspc_code_t appCur [3];
    lspc_duty_t appDuty [3];
    logic [2:0] curBusy;
    logic [2:0] dutyBusy;
    logic [2:0] enEff;
    logic [2:0] rampOn;
    logic [6:0] phase;

    // registered outputs
    logic [2:0] next_sinkOn;
    logic [2:0] next_pwmActive;
    lspc_code_t next_sinkCode [3];

    logic [7:0] idx;
    logic wrTake;
    lspc_code_t wrByte;

    function automatic logic isMapped(input logic [7:0] i);
        isMapped = (i >= `LSPC_IDX_BOOST_INCL) && (i <= `LSPC_IDX_APP_CUR3);
    endfunction

    function automatic logic dutyOn(input logic [6:0] ph, input lspc_duty_t d);
        dutyOn = (ph < d);
    endfunction

    function automatic lspc_code_t regRead(input logic [7:0] i);
        case (i)
            `LSPC_IDX_BOOST_INCL: regRead = {4'h0, incl, 1'b0};
            `LSPC_IDX_CTRL: regRead = {1'b0, ctrl[6:0]};
            `LSPC_IDX_IDLE: regRead = idleCode;
            `LSPC_IDX_CUR1: regRead = curCode[0];
            `LSPC_IDX_CUR2: regRead = curCode[1];
            `LSPC_IDX_CUR3: regRead = curCode[2];
            `LSPC_IDX_DUTY1: regRead = dutyReg[0];
            `LSPC_IDX_DUTY2: regRead = dutyReg[1];
            `LSPC_IDX_DUTY3: regRead = dutyReg[2];
            `LSPC_IDX_STATUS: regRead = {2'h0, dutyBusy, curBusy};
            `LSPC_IDX_APP_DUTY1: regRead = {1'b0, appDuty[0]};
            `LSPC_IDX_APP_DUTY2: regRead = {1'b0, appDuty[1]};
            `LSPC_IDX_APP_DUTY3: regRead = {1'b0, appDuty[2]};
            `LSPC_IDX_APP_CUR1: regRead = appCur[0];
            `LSPC_IDX_APP_CUR2: regRead = appCur[1];
            `LSPC_IDX_APP_CUR3: regRead = appCur[2];
            default: regRead = 8'h00;
        endcase
    endfunction

    assign idx = address[9:2];
    assign wrByte = writedata[7:0];
    assign wrTake = (busState == BUS_ANSWER) && write && byteenable[0]
        && isMapped(idx);

    // avalon slave: one wait cycle, answer on the second
    always_comb begin
        next_busState = busState;
        next_waitrequest = 1'b1;
        next_readdata = readdata;
        case (busState)
            BUS_IDLE: begin
                if (read || write) begin
                    next_busState = BUS_ANSWER;
                    next_waitrequest = 1'b0;
                    next_readdata = 32'h00000000;
                    if (read) begin
                        next_readdata = {24'h000000, regRead(idx)};
                    end
                end
            end
            BUS_ANSWER: begin
                next_busState = BUS_IDLE;
                next_waitrequest = 1'b1;
            end
            default: begin
                next_busState = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            busState <= BUS_IDLE;
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else begin
            busState <= next_busState;
            waitrequest <= next_waitrequest;
            readdata <= next_readdata;
        end
    end

    // register writes with automatic clearing
    always_comb begin
        next_ctrl = ctrl;
        next_idleCode = idleCode;
        next_incl = incl;
        for (int s = 0; s < 3; s++) begin
            next_curCode[s] = curCode[s];
            next_dutyReg[s] = dutyReg[s];
        end
        if (wrTake) begin
            case (idx)
                `LSPC_IDX_BOOST_INCL: next_incl = wrByte[`LSPC_INCL_LSB +: 3];
                `LSPC_IDX_CTRL: next_ctrl = {1'b0, wrByte[6:0]};
                `LSPC_IDX_IDLE: next_idleCode = wrByte;
                `LSPC_IDX_CUR1: next_curCode[0] = wrByte;
                `LSPC_IDX_CUR2: next_curCode[1] = wrByte;
                `LSPC_IDX_CUR3: next_curCode[2] = wrByte;
                `LSPC_IDX_DUTY1: next_dutyReg[0] = wrByte;
                `LSPC_IDX_DUTY2: next_dutyReg[1] = wrByte;
                `LSPC_IDX_DUTY3: next_dutyReg[2] = wrByte;
                default: next_ctrl = ctrl;
            endcase
        end
        if (!next_ctrl[`LSPC_CTRL_MODE3]) begin
            next_ctrl[`LSPC_CTRL_EN3] = 1'b0;
        end
        next_incl = next_incl & {next_ctrl[`LSPC_CTRL_EN3],
            next_ctrl[`LSPC_CTRL_EN2], next_ctrl[`LSPC_CTRL_EN1]};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl <= `LSPC_CTRL_RESET;
            idleCode <= `LSPC_CODE_RESET;
            incl <= `LSPC_INCL_RESET;
            for (int s = 0; s < 3; s++) begin
                curCode[s] <= `LSPC_CODE_RESET;
                dutyReg[s] <= `LSPC_DUTY_RESET;
            end
        end else begin
            ctrl <= next_ctrl;
            idleCode <= next_idleCode;
            incl <= next_incl;
            for (int s = 0; s < 3; s++) begin
                curCode[s] <= next_curCode[s];
                dutyReg[s] <= next_dutyReg[s];
            end
        end
    end

    assign enEff = {ctrl[`LSPC_CTRL_EN3], ctrl[`LSPC_CTRL_EN2], ctrl[`LSPC_CTRL_EN1]};
    assign rampOn = {ctrl[`LSPC_CTRL_RAMP3], ctrl[`LSPC_CTRL_RAMP2],
        ctrl[`LSPC_CTRL_RAMP1]};

    lspc_pwm #(
        .TICK_CYCLES(PWM_TICK_CYCLES),
        .PERIOD(PWM_PERIOD)
    ) u_pwm (
        .clock(clock),
        .rst(rst),
        .phase(phase)
    );

    for (genvar s = 0; s < 3; s++) begin : g_sink
        lspc_step #(
            .W(8),
            .STEP_CYCLES(RAMP_STEP_CYCLES)
        ) u_cur (
            .clock(clock),
            .rst(rst),
            .target(curCode[s]),
            .rampOn(rampOn[s]),
            .forceLoad(1'b0),
            .value(appCur[s]),
            .busy(curBusy[s])
        );
        lspc_step #(
            .W(7),
            .STEP_CYCLES(DIM_STEP_CYCLES)
        ) u_duty (
            .clock(clock),
            .rst(rst),
            .target(dutyReg[s][6:0]),
            .rampOn(dutyReg[s][`LSPC_DUTY_DIM]),
            .forceLoad(dutyReg[s][6:0] == 7'h00),
            .value(appDuty[s]),
            .busy(dutyBusy[s])
        );
    end

    // pwm compare and current selection per sink
    always_comb begin
        next_sinkOn = 3'h0;
        next_pwmActive = 3'h0;
        for (int s = 0; s < 3; s++) begin
            next_pwmActive[s] = dutyOn(phase, appDuty[s]);
            next_sinkOn[s] = enEff[s];
            next_sinkCode[s] = 8'h00;
            if (enEff[s]) begin
                if (next_pwmActive[s]) begin
                    next_sinkCode[s] = appCur[s];
                end else begin
                    next_sinkCode[s] = idleCode;
                end
            end
        end
        if (!ctrl[`LSPC_CTRL_MODE3]) begin
            next_sinkOn[2] = 1'b0;
            next_sinkCode[2] = 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sinkOn <= 3'h0;
            pwmActive <= 3'h0;
            boostInclusion <= 3'h0;
            sink1Code <= 8'h00;
            sink2Code <= 8'h00;
            sink3Code <= 8'h00;
        end else begin
            sinkOn <= next_sinkOn;
            pwmActive <= next_pwmActive;
            boostInclusion <= next_incl;
            sink1Code <= next_sinkCode[0];
            sink2Code <= next_sinkCode[1];
            sink3Code <= next_sinkCode[2];
        end
    end
endmodule // lspc_top

// [verification/lspc_top_chk.sv]
`timescale 1ns/1ns
module lspc_top_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [2:0] sinkOn,
    input wire logic [2:0] pwmActive,
    input wire logic [2:0] boostInclusion,
    input wire lspc_pkg::lspc_code_t sink1Code,
    input wire lspc_pkg::lspc_code_t sink2Code,
    input wire lspc_pkg::lspc_code_t sink3Code
);
    import lspc_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_ACK: assert property ($rose(read | write) |=> !waitrequest)
        else $error("answer not one cycle after request");
    AST_ONE: assert property (!waitrequest |=> waitrequest)
        else $error("answer longer than one cycle");
    AST_UPPER: assert property (readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_HOLD: assert property (!$stable(readdata) |-> !waitrequest)
        else $error("read data changed outside answer");
    AST_INCL: assert property ((boostInclusion & ~sinkOn) == 3'h0)
        else $error("inclusion set on disabled sink");
    AST_OFF1: assert property (!sinkOn[0] |-> sink1Code == 8'h00)
        else $error("sink1 code while disabled");
    AST_OFF2: assert property (!sinkOn[1] |-> sink2Code == 8'h00)
        else $error("sink2 code while disabled");
    AST_OFF3: assert property (!sinkOn[2] |-> sink3Code == 8'h00)
        else $error("sink3 code while disabled");
endmodule // lspc_top_chk

// [verification/lspc_top_tb.sv]
`timescale 1ns/1ns
module lspc_top_tb;
    import lspc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [9:0] address = 10'h000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata;
    logic waitrequest;
    logic [2:0] sinkOn, pwmActive, boostInclusion;
    lspc_code_t sink1Code, sink2Code, sink3Code;
    int nFail = 0;
    int checkCount = 0;
    int cycles = 0;
    lspc_top #(.RAMP_STEP_CYCLES(20), .DIM_STEP_CYCLES(30), .PWM_TICK_CYCLES(2),
        .PWM_PERIOD(95)) u_lspc_top (.clock(clock), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .sinkOn(sinkOn),
        .pwmActive(pwmActive), .boostInclusion(boostInclusion), .sink1Code(sink1Code),
        .sink2Code(sink2Code), .sink3Code(sink3Code));
    initial begin
        forever #5 clock = ~clock;
    end
    task completeRun;
        if (nFail == 0 && checkCount > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nFail++;
            completeRun();
        end
    end
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checkCount++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
        output logic [7:0] q);
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        read <= ~wr;
        write <= wr;
        @(posedge clock);
        while (waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk("readback", exp, q);
    endtask
    task meas(input int s, input logic [7:0] exp);
        int c;
        c = 0;
        cyc(4);
        repeat (190) begin
            @(posedge clock);
            if (pwmActive[s] === 1'b1) c++;
        end
        chk("pwm active cycles", exp, c[7:0]);
    endtask
    task waitAct(input logic want, input logic [7:0] exp);
        int n;
        n = 0;
        cyc(2);
        while (pwmActive[0] !== want && n < 400) begin
            @(posedge clock);
            n++;
        end
        chk("sink1 code", exp, sink1Code);
    endtask
    task tReset;
        rd(8'h47, 8'h40);
        rd(8'h48, 8'h00);
        rd(8'h49, 8'h00);
        rd(8'h4c, 8'h00);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        byteenable <= 4'he;
        wr(8'h48, 8'h5a);
        byteenable <= 4'hf;
        rd(8'h48, 8'h00);
    endtask
    task tPwm;
        logic [7:0] duty [4];
        logic [7:0] expc [4];
        duty = '{8'h00, 8'h30, 8'h5f, 8'h7f};
        expc = '{8'h00, 8'd96, 8'd190, 8'd190};
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < 4; k++) begin
                wr(8'(8'h4c + s), duty[k]);
                meas(s, expc[k]);
            end
        end
    endtask
    task tCode;
        wr(8'h48, 8'h11);
        wr(8'h49, 8'h80);
        rd(8'h53, 8'h80);
        wr(8'h4c, 8'h30);
        rd(8'h50, 8'h30);
        wr(8'h47, 8'h41);
        waitAct(1'b1, 8'h80);
        waitAct(1'b0, 8'h11);
    endtask
    task tIncl;
        wr(8'h46, 8'h02);
        cyc(3);
        chk("inclusion", 8'h01, {7'h0, boostInclusion[0]});
        wr(8'h47, 8'h40);
        cyc(3);
        chk("sink on", 8'h00, {7'h0, sinkOn[0]});
        chk("inclusion", 8'h00, {7'h0, boostInclusion[0]});
        rd(8'h46, 8'h00);
    endtask
    task tRamp;
        wr(8'h47, 8'h43);
        wr(8'h49, 8'h84);
        cyc(23);
        rd(8'h53, 8'h81);
        rd(8'h4f, 8'h01);
        cyc(70);
        rd(8'h53, 8'h84);
        rd(8'h4f, 8'h00);
    endtask
    task tDim;
        wr(8'h4c, 8'hb4);
        cyc(29);
        rd(8'h50, 8'h31);
        cyc(110);
        rd(8'h50, 8'h34);
        wr(8'h4c, 8'h80);
        rd(8'h50, 8'h00);
    endtask
    task tMode;
        wr(8'h4b, 8'hff);
        wr(8'h47, 8'h10);
        rd(8'h47, 8'h00);
        cyc(3);
        chk("sink3 on", 8'h00, {7'h0, sinkOn[2]});
        chk("sink3 code", 8'h00, sink3Code);
        wr(8'h47, 8'h50);
        rd(8'h47, 8'h50);
        cyc(3);
        chk("sink3 on", 8'h01, {7'h0, sinkOn[2]});
        chk("sink3 code", 8'hff, sink3Code);
    endtask
    task tSink2;
        wr(8'h4a, 8'h5a);
        wr(8'h47, 8'h44);
        cyc(3);
        chk("sink2 on", 8'h01, {7'h0, sinkOn[1]});
        chk("sink2 code", 8'h5a, sink2Code);
        chk("sink3 on", 8'h00, {7'h0, sinkOn[2]});
    endtask
    initial begin
        cyc(16);
        rst <= 1'b0;
        cyc(1);
        tReset();
        tPwm();
        tCode();
        tIncl();
        tRamp();
        tDim();
        tMode();
        tSink2();
        completeRun();
    end
endmodule // lspc_top_tb
bind lspc_top lspc_top_chk u_lspc_top_chk (.clock(clock), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .sinkOn(sinkOn),
    .pwmActive(pwmActive), .boostInclusion(boostInclusion), .sink1Code(sink1Code),
    .sink2Code(sink2Code), .sink3Code(sink3Code));
